// *** common/iso_wb_defines.vh ***
/*
 holds field positions, widths and limits of the isochronous descriptor rows.
 assumes rows of 64 bits, a row being an even/odd double-word pair.
*/
`ifndef ISO_WB_DEFINES_VH
`define ISO_WB_DEFINES_VH
`define CNT_W          12
`define DONE_W         15
`define DONE_MAX       15'h7fff
`define RES_W          3
`define UF_NUM         8
`define ROW_W          64
`define ROW_A_W        2
`define ROW_DW0        2'h0
`define ROW_DW2        2'h1
`define ROW_DW4        2'h2
`define ROW_DW6        2'h3
`define UF7_HI         63
`define UF6_HI         51
`define UF5_HI_HI      39
`define UF5_LO_HI      31
`define UF4_HI         27
`define UF3_HI         15
`define UF2_HI_HI      3
`define UF2_LO_HI      63
`define UF1_HI         55
`define UF0_HI         43
`define DONE_LSB       32
`define RES_LSB        8
`define MASK_LSB       0
`define FIFO_DEPTH     8
`define FIFO_A_W       3
`define RES_ERR_BIT    0
`define RES_BABBLE_BIT 1
`define RES_UNDER_BIT  2
`define WB_W           19
`endif

// *** dv/iso_desc_writeback_tb.sv ***
/* bench for the writeback: placement, skips, burst, saturation.
   assumes the endpoint model feeds results to the top ports. */
`default_nettype none
module iso_desc_writeback_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        load_en = 1'b0;
   logic        stall = 1'b0;
   logic [1:0]  load_row = 2'h0;
   logic [1:0]  read_row = 2'h0;
   logic [7:0]  sched = 8'h05;
   logic [63:0] load_data = 64'h0;
   logic [63:0] e2, e3;
   wire logic [63:0] rdata;
   wire logic [14:0] total;
   wire logic [11:0] cnt;
   wire logic [7:0]  fr;
   wire logic [2:0]  uf;
   wire logic        ready, valid, is_in, err, bab, und, done;
   int failures = 0, num_checks = 0, cyc = 0, dones = 0, tot = 0;
   iso_desc_writeback u_dut (.clk_sys_in, .rst_n_in, .load_en_in(load_en),
      .load_row_in(load_row), .load_data_in(load_data), .read_row_in(read_row),
      .read_data_out(rdata), .sched_frame_in(sched), .res_valid_in(valid),
      .res_ready_out(ready), .res_uframe_in(uf), .res_frame_in(fr), .res_count_in(cnt),
      .res_is_in_in(is_in), .res_err_in(err), .res_babble_in(bab),
      .res_underrun_in(und), .wb_done_out(done), .bytes_done_count_out(total));
   iso_ep_model u_ep (.clk_sys_in, .ready_in(ready), .valid_out(valid), .uframe_out(uf),
      .frame_out(fr), .count_out(cnt), .is_in_out(is_in), .err_out(err),
      .babble_out(bab), .underrun_out(und));
   initial forever #2 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (done === 1'b1) dones <= dones + 1;
      if (valid === 1'b1 && ready === 1'b0) stall <= 1'b1;
      if (cyc == 5000) begin
         failures = failures + 1;
         end_sim;
      end
   end
   task automatic end_sim;
      if (failures == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic load(input logic [1:0] r, input logic [63:0] d);
      @(negedge clk_sys_in);
      load_en <= 1'b1;
      load_row <= r;
      load_data <= d;
      @(negedge clk_sys_in);
      load_en <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] r, output logic [63:0] d);
      @(negedge clk_sys_in);
      read_row <= r;
      repeat (3) @(negedge clk_sys_in);
      d = rdata;
   endtask
   task automatic settle(input int n);
      for (int i = 0; i < 400 && dones < n; i++) @(negedge clk_sys_in);
      chk("done count", 64'(n), 64'(dones));
   endtask
   task automatic t_place;
      logic [11:0] c[8];
      logic [2:0]  st[8];
      logic [63:0] got;
      int          d0;
      d0 = dones;
      load(2'h2, 64'hff);
      for (int i = 0; i < 8; i++) begin
         c[i] = 12'h0a5 + 12'(i) * 12'h1f3;
         st[i] = {~i[0], i[0], i[1]};
         tot += c[i];
         u_ep.put(3'(i), 8'h05, c[i], {i[0], i[1], 2'b11});
      end
      settle(d0 + 8);
      e3 = {c[7], c[6], c[5], c[4], c[3], c[2][11:8]};
      e2 = {c[2][7:0], c[1], c[0], st[7], st[6], st[5], st[4], st[3], st[2], st[1],
            st[0], 8'hff};
      rd(2'h3, got);
      chk("row 3", e3, got);
      rd(2'h2, got);
      chk("row 2", e2, got);
      rd(2'h1, got);
      chk("row 1", 64'(tot) << 32, got);
      chk("total", 64'(tot), 64'(total));
   endtask
   task automatic t_skip;
      logic [63:0] got;
      int          d0;
      d0 = dones;
      load(2'h2, 64'h7f);
      u_ep.put(3'h7, 8'h05, 12'h123, 4'b0100);
      sched <= 8'h06;
      u_ep.put(3'h0, 8'h05, 12'h321, 4'b1010);
      settle(d0 + 2);
      sched <= 8'h05;
      e2 = 64'h0000_0000_2000_027f;
      rd(2'h3, got);
      chk("row 3", e3, got);
      rd(2'h2, got);
      chk("row 2", e2, got);
      chk("total", 64'(tot), 64'(total));
   endtask
   task automatic t_burst;
      logic [63:0] got;
      int          d0;
      d0 = dones;
      for (int i = 1; i <= 20; i++) begin
         u_ep.put(3'h2, 8'h05, 12'(i), 4'b0000);
         tot += i;
      end
      settle(d0 + 20);
      chk("fifo stalled", 64'h1, 64'(stall));
      rd(2'h2, got);
      chk("row 2", e2 | 64'h1400_0000_0000_0000, got);
      rd(2'h3, got);
      chk("row 3", {e3[63:4], 4'h0}, got);
      chk("total", 64'(tot), 64'(total));
   endtask
   task automatic t_sat;
      logic [63:0] got;
      int          d0;
      d0 = dones;
      load(2'h1, 64'h0000_7ff0_0000_0000);
      rd(2'h1, got);
      chk("total", 64'h7ff0, 64'(total));
      u_ep.put(3'h1, 8'h05, 12'h0ff, 4'b0000);
      settle(d0 + 1);
      chk("total", 64'h7fff, 64'(total));
      rd(2'h1, got);
      chk("row 1", 64'h0000_7fff_0000_0000, got);
   endtask
   initial begin
      repeat (3) @(negedge clk_sys_in);
      rst_n_in <= 1'b1;
      t_place;
      t_skip;
      t_burst;
      t_sat;
      end_sim;
   end
endmodule // iso_desc_writeback_tb
`default_nettype wire

// *** dv/iso_ep_model.sv ***
/* result source standing for the endpoint traffic and its scheduler.
   assumes ready is registered and the bench calls put. */
`default_nettype none
module iso_ep_model (
   input  wire logic        clk_sys_in,
   input  wire logic        ready_in,
   output var  logic        valid_out,
   output wire logic [2:0]  uframe_out,
   output wire logic [7:0]  frame_out,
   output wire logic [11:0] count_out,
   output wire logic        is_in_out,
   output wire logic        err_out,
   output wire logic        babble_out,
   output wire logic        underrun_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [26:0] b_q = 27'h0;
   assign {uframe_out, frame_out, count_out, is_in_out, err_out, babble_out,
           underrun_out} = b_q;
   initial valid_out = 1'b0;
   // flg is in token, error, babble, underrun
   task automatic put(input logic [2:0] uf, input logic [7:0] fr,
                      input logic [11:0] cnt, input logic [3:0] flg);
      @(negedge clk_sys_in);
      b_q <= {uf, fr, cnt, flg};
      valid_out <= 1'b1;
      while (ready_in !== 1'b1) @(negedge clk_sys_in);
      @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      valid_out <= 1'b0;
      // released lines show garbage, not the last result
      b_q <= ~b_q;
   endtask
endmodule // iso_ep_model
`default_nettype wire

// *** dv/iso_wb_monitor.sv ***
/* checker on the writeback top ports.
   assumes one clock and a bind onto the top module. */
`default_nettype none
module iso_wb_monitor (
   input wire logic        clk_sys_in,
   input wire logic        rst_n_in,
   input wire logic        load_en_in,
   input wire logic [1:0]  read_row_in,
   input wire logic        res_valid_in,
   input wire logic        res_ready_out,
   input wire logic        wb_done_out,
   input wire logic [14:0] bytes_done_count_out,
   input wire logic [63:0] read_data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] pend_q, age_q, quiet_q;
   logic [1:0] up_q;
   wire        take = res_valid_in & res_ready_out;
   wire        busy = take | load_en_in | wb_done_out;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {pend_q, age_q, quiet_q, up_q} <= 14'h0;
      end else begin
         pend_q  <= pend_q + 4'(take) - 4'(wb_done_out);
         age_q   <= load_en_in ? 4'h0 : age_q + 4'(age_q != 4'hf);
         quiet_q <= (busy || read_row_in != $past(read_row_in)) ? 4'h0
                    : quiet_q + 4'(quiet_q != 4'hf);
         up_q    <= up_q + 2'(up_q != 2'h3);
      end
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   a_done_single: assert property (wb_done_out |=> !wb_done_out [*4])
      else $error("done pulse too long or too close");
   a_done_owed: assert property (wb_done_out |-> pend_q != 4'h0)
      else $error("done without a taken result");
   a_done_prompt: assert property (pend_q != 4'h0 && age_q > 4'h8 |-> ##[0:12] wb_done_out)
      else $error("queued result not written back");
   // ready lags by a cycle, so only an idle stretch proves the fifo empty
   a_ready_idle: assert property (up_q == 2'h3 && pend_q == 4'h0 && $past(pend_q) == 4'h0
      |-> res_ready_out)
      else $error("ready low while idle");
   a_total_rise: assert property (age_q > 4'h8
      |-> bytes_done_count_out >= $past(bytes_done_count_out))
      else $error("total fell without a load");
   a_total_step: assert property (age_q > 4'h8
      |-> bytes_done_count_out - $past(bytes_done_count_out) <= 15'h0fff)
      else $error("total grew by more than one count");
   a_total_sat: assert property (age_q > 4'h8 && $past(bytes_done_count_out) == 15'h7fff
      |-> bytes_done_count_out == 15'h7fff)
      else $error("total left saturation");
   a_read_quiet: assert property (quiet_q > 4'h8 && pend_q == 4'h0
      |-> $stable(read_data_out))
      else $error("row changed with no write");
endmodule // iso_wb_monitor
bind iso_desc_writeback iso_wb_monitor u_mon (.clk_sys_in, .rst_n_in, .load_en_in,
   .read_row_in, .res_valid_in, .res_ready_out, .wb_done_out, .bytes_done_count_out,
   .read_data_out);
`default_nettype wire

// *** logic/iso_desc_mem.v ***
/*
 holds the four 64-bit rows of one isochronous descriptor.
 assumes one writer with per-bit enables; read data is registered.
*/
`default_nettype none
module iso_desc_mem (
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   input  wire        we_in,
   input  wire [1:0]  waddr_in,
   input  wire [63:0] wbits_in,
   input  wire [63:0] wdata_in,
   input  wire [1:0]  raddr_in,
   output reg  [63:0] rdata_out
);
   reg [63:0] row_q [0:3];
   integer i;
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (i = 0; i < 4; i = i + 1) row_q[i] <= 64'h0;
         rdata_out <= 64'h0;
      end else begin
         if (we_in) begin
            row_q[waddr_in] <= (row_q[waddr_in] & ~wbits_in) | (wdata_in & wbits_in);
         end
         rdata_out <= row_q[raddr_in];
      end
   end
endmodule // iso_desc_mem
`default_nettype wire

// *** logic/iso_desc_writeback.v ***
/*
 holds the isochronous descriptor store and the per-microframe result writeback.
 assumes software loads rows through the load port and the scheduler reports
 one result per microframe with the frame number it was scheduled for.
*/
`default_nettype none
`include "iso_wb_defines.vh"
module iso_desc_writeback (
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   input  wire        load_en_in,
   input  wire [1:0]  load_row_in,
   input  wire [63:0] load_data_in,
   input  wire [1:0]  read_row_in,
   output reg  [63:0] read_data_out,
   input  wire [7:0]  sched_frame_in,
   input  wire        res_valid_in,
   output reg         res_ready_out,
   input  wire [2:0]  res_uframe_in,
   input  wire [7:0]  res_frame_in,
   input  wire [11:0] res_count_in,
   input  wire        res_is_in_in,
   input  wire        res_err_in,
   input  wire        res_babble_in,
   input  wire        res_underrun_in,
   output reg         wb_done_out,
   output reg  [14:0] bytes_done_count_out
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_RD4   = 3'h1;
   localparam ST_WAIT4 = 3'h2;
   localparam ST_WR    = 3'h3;
   localparam ST_WR2   = 3'h4;
   localparam ST_WR3   = 3'h5;

   reg  [2:0]   st_q;
   reg  [18:0]  ent_q;
   reg  [7:0]   mask_q;
   reg  [14:0]  done_q;
   reg  [3:0]   occ_q;
   reg  [3:0]   occ_d;
   reg          we;
   reg  [1:0]   waddr;
   reg  [63:0]  wbits;
   reg  [63:0]  wdata;
   reg  [1:0]   raddr;
   reg  [2:0]   code;
   reg  [15:0]  sum;
   reg  [14:0]  total_d;
   reg  [63:0]  r2_bits;
   reg  [63:0]  r2_data;
   reg  [63:0]  r3_bits;
   reg  [63:0]  r3_data;
   reg  [63:0]  r1_bits;
   reg  [63:0]  r1_data;
   wire         f_valid;
   wire         f_ready;
   wire [18:0]  f_data;
   wire         in_rdy;
   wire [63:0]  mem_rd;
   wire [2:0]   uf;
   wire [11:0]  cnt;
   wire [18:0]  packed_res;
   wire         push;
   wire         pop;
   wire         upd;
   wire         r3_hit;

   // results are queued so a burst of microframe reports is not lost while the
   // engine does its read-modify-write of the mask row
   assign packed_res = {res_uframe_in, res_count_in, code, res_frame_in == sched_frame_in};
   always @* begin
      code = 3'h0;
      code[`RES_ERR_BIT]    = res_err_in;
      code[`RES_BABBLE_BIT] = res_babble_in & res_is_in_in;
      code[`RES_UNDER_BIT]  = res_underrun_in & ~res_is_in_in;
   end

   iso_result_fifo #(
      .WIDTH (`WB_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_A_W)
   ) u_fifo (
      .clk_sys_in    (clk_sys_in),
      .rst_n_in      (rst_n_in),
      .in_valid_in   (push),
      .in_ready_out  (in_rdy),
      .in_data_in    (packed_res),
      .out_valid_out (f_valid),
      .out_ready_in  (f_ready),
      .out_data_out  (f_data)
   );

   iso_desc_mem u_mem (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .we_in      (we),
      .waddr_in   (waddr),
      .wbits_in   (wbits),
      .wdata_in   (wdata),
      .raddr_in   (raddr),
      .rdata_out  (mem_rd)
   );

   assign f_ready = (st_q == ST_IDLE) && !load_en_in;
   assign pop     = f_valid & f_ready;
   assign push    = res_valid_in & res_ready_out & in_rdy;
   assign uf      = ent_q[18:16];
   assign cnt     = ent_q[15:4];
   // a slot's count and the total move only for a live slot in the right frame
   assign upd     = ent_q[0] & mask_q[uf];
   assign r3_hit  = (uf >= 3'h2);

   // ready is registered, so it looks at the occupancy after this edge: a
   // result held under a high ready is never refused by a full queue
   always @* begin
      occ_d = occ_q + {3'h0, push} - {3'h0, pop};
   end

   always @* begin
      sum     = {1'b0, done_q} + {4'h0, cnt};
      total_d = sum[15] ? `DONE_MAX : sum[14:0];
   end

   // row 2 (DW5:DW4): the slot's status always, counts of slots 0..1 and the low byte of slot 2
   always @* begin
      r2_bits = 64'h0;
      r2_data = 64'h0;
      r2_bits[`RES_LSB + uf*3 +: 3] = 3'h7;
      r2_data[`RES_LSB + uf*3 +: 3] = ent_q[3:1];
      case (uf)
         3'h2: begin
            r2_bits[`UF2_LO_HI -: 8] = 8'hff;
            r2_data[`UF2_LO_HI -: 8] = cnt[7:0];
         end
         3'h1: begin
            r2_bits[`UF1_HI -: 12] = 12'hfff;
            r2_data[`UF1_HI -: 12] = cnt;
         end
         3'h0: begin
            r2_bits[`UF0_HI -: 12] = 12'hfff;
            r2_data[`UF0_HI -: 12] = cnt;
         end
         default: begin
            r2_bits[63:32] = 32'h0;
         end
      endcase
      // status still lands for a dead slot so software sees what happened
      if (!upd) begin
         r2_bits[63:32] = 32'h0;
      end
   end

   // row 3 (DW7:DW6): counts of slots 3..7 and the high nibble of slot 2
   always @* begin
      r3_bits = 64'h0;
      r3_data = 64'h0;
      case (uf)
         3'h7: begin
            r3_bits[`UF7_HI -: 12] = 12'hfff;
            r3_data[`UF7_HI -: 12] = cnt;
         end
         3'h6: begin
            r3_bits[`UF6_HI -: 12] = 12'hfff;
            r3_data[`UF6_HI -: 12] = cnt;
         end
         3'h5: begin
            r3_bits[`UF5_HI_HI -: 8] = 8'hff;
            r3_data[`UF5_HI_HI -: 8] = cnt[11:4];
            r3_bits[`UF5_LO_HI -: 4] = 4'hf;
            r3_data[`UF5_LO_HI -: 4] = cnt[3:0];
         end
         3'h4: begin
            r3_bits[`UF4_HI -: 12] = 12'hfff;
            r3_data[`UF4_HI -: 12] = cnt;
         end
         3'h3: begin
            r3_bits[`UF3_HI -: 12] = 12'hfff;
            r3_data[`UF3_HI -: 12] = cnt;
         end
         3'h2: begin
            r3_bits[`UF2_HI_HI -: 4] = 4'hf;
            r3_data[`UF2_HI_HI -: 4] = cnt[11:8];
         end
         default: begin
            r3_bits = 64'h0;
         end
      endcase
   end

   // row 1 (DW3:DW2): only the transferred total, saturated
   always @* begin
      r1_bits = 64'h0;
      r1_data = 64'h0;
      r1_bits[`DONE_LSB +: `DONE_W] = {`DONE_W{1'b1}};
      r1_data[`DONE_LSB +: `DONE_W] = total_d;
   end

   // single write port: software load has priority, the engine waits for as long as load_en_in is high
   always @* begin
      we    = 1'b0;
      waddr = `ROW_DW0;
      wbits = 64'h0;
      wdata = 64'h0;
      raddr = read_row_in;
      if (load_en_in) begin
         we    = 1'b1;
         waddr = load_row_in;
         wbits = {64{1'b1}};
         wdata = load_data_in;
      end else begin
         case (st_q)
            ST_RD4, ST_WAIT4: begin
               raddr = `ROW_DW4;
            end
            ST_WR: begin
               we    = 1'b1;
               waddr = `ROW_DW4;
               wbits = r2_bits;
               wdata = r2_data;
            end
            ST_WR2: begin
               we    = upd & r3_hit;
               waddr = `ROW_DW6;
               wbits = r3_bits;
               wdata = r3_data;
            end
            ST_WR3: begin
               we    = upd;
               waddr = `ROW_DW2;
               wbits = r1_bits;
               wdata = r1_data;
            end
            default: begin
               we    = 1'b0;
            end
         endcase
      end
   end

   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q                 <= ST_IDLE;
         ent_q                <= 19'h0;
         mask_q               <= 8'h0;
         done_q               <= 15'h0;
         occ_q                <= 4'h0;
         res_ready_out        <= 1'b0;
         wb_done_out          <= 1'b0;
         bytes_done_count_out <= 15'h0;
         read_data_out        <= 64'h0;
      end else begin
         occ_q                <= occ_d;
         res_ready_out        <= (occ_d < `FIFO_DEPTH);
         read_data_out        <= mem_rd;
         wb_done_out          <= 1'b0;
         bytes_done_count_out <= done_q;
         if (load_en_in && load_row_in == `ROW_DW2) begin
            done_q <= load_data_in[`DONE_LSB +: `DONE_W];
         end
         case (st_q)
            ST_IDLE: begin
               if (f_valid && f_ready) begin
                  ent_q <= f_data;
                  st_q  <= ST_RD4;
               end
            end
            ST_RD4: begin
               if (!load_en_in) st_q <= ST_WAIT4;
            end
            ST_WAIT4: begin
               if (load_en_in) begin
                  st_q <= ST_RD4;
               end else begin
                  mask_q <= mem_rd[`MASK_LSB +: `UF_NUM];
                  st_q   <= ST_WR;
               end
            end
            ST_WR: begin
               if (!load_en_in) st_q <= ST_WR2;
            end
            ST_WR2: begin
               if (!load_en_in) st_q <= ST_WR3;
            end
            ST_WR3: begin
               if (!load_en_in) begin
                  if (upd) done_q <= total_d;
                  wb_done_out <= 1'b1;
                  st_q        <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
endmodule // iso_desc_writeback
`default_nettype wire

// *** logic/iso_result_fifo.v ***
/*
 holds a small valid/ready fifo for microframe results.
 assumes a single clock and that the drain side may stall.
*/
`default_nettype none
module iso_result_fifo #(
   parameter WIDTH = 19,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk_sys_in,
   input  wire             rst_n_in,
   input  wire             in_valid_in,
   output wire             in_ready_out,
   input  wire [WIDTH-1:0] in_data_in,
   output wire             out_valid_out,
   input  wire             out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg  [AW:0]      wr_q;
   reg  [AW:0]      rd_q;
   wire             full;
   wire             empty;
   assign empty = (wr_q == rd_q);
   assign full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready_out  = ~full;
   assign out_valid_out = ~empty;
   assign out_data_out  = mem_q[rd_q[AW-1:0]];
   always @(posedge clk_sys_in) begin
      if (in_valid_in && !full) begin
         mem_q[wr_q[AW-1:0]] <= in_data_in;
      end
   end
   always @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
      end else begin
         if (in_valid_in && !full) wr_q <= wr_q + 1'b1;
         if (out_ready_in && !empty) rd_q <= rd_q + 1'b1;
      end
   end
endmodule // iso_result_fifo
`default_nettype wire
